// >>> logic/hbs_pkg.sv
/*
  Shared constants for the parallel host bus attachment: window map,
  strap codes, host bus timing and the controller's register map.
  Assumes a single 200 MHz clock for both ends.
*/
package hbs_pkg;
  // Window and buffer geometry in bytes.
  localparam int WIN_BYTES = 131072;
  localparam int BUF_BYTES = 81920;
  localparam int BUF_WORDS = BUF_BYTES / 2;
  localparam logic [16:0] BUF_END = 17'h14000;
  localparam logic [16:0] REG_BASE = 17'h1ffe0;
  localparam logic [4:0] REV_REG_OFS = 5'h00;
  // Revision code; the value is arbitrary.
  localparam logic [7:0] REV_CODE = 8'h5a;
  // Strap codes selecting generic host bus mode one.
  localparam logic [2:0] MODE_STRAPS = 3'h7;
  localparam logic BUS_START_GENERIC = 1'b0;
  // Select delay after address: half a bus clock, rounded up to cycles.
  localparam int CLK_PS = 5000;
  localparam int SEL_DELAY_PS = 2500;
  localparam int SEL_DELAY_CYC_RAW = (SEL_DELAY_PS + CLK_PS - 1) / CLK_PS;
  localparam int SEL_DELAY_CYC = (SEL_DELAY_CYC_RAW < 1) ? 1 : SEL_DELAY_CYC_RAW;
  // Controller register byte offsets on the AXI4-Lite port.
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RDATA_OFS = 8'h10;
  // Command register fields.
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_LANE_LSB = 2;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/hbs_if.sv
/*
  Pin-level carrier between the host bus controller and the display
  controller end. Resolves the shared data bus and the acknowledge line.
  Assumes the acknowledge line has a pull-down when undriven.
*/
`timescale 1ns/1ps
interface hbs_if;
  logic [16:0] addr;
  logic cs_n;
  logic low_byte_write_strobe_n;
  logic high_byte_write_strobe_n;
  logic low_byte_read_strobe_n;
  logic high_byte_read_strobe_n;
  logic [15:0] host_dout;
  logic host_doe;
  logic [15:0] dev_dout;
  logic dev_doe;
  logic dev_ack;
  logic dev_ack_oe;
  logic [15:0] data_bus;
  logic ack_line;

  // Shared wires resolved from the enables.
  assign data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 16'h0000);
  assign ack_line = dev_ack_oe & dev_ack;

  modport host (
    output addr, cs_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
    output low_byte_read_strobe_n, high_byte_read_strobe_n, host_dout, host_doe,
    input data_bus, ack_line
  );
  modport device (
    input addr, cs_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
    input low_byte_read_strobe_n, high_byte_read_strobe_n, data_bus,
    output dev_dout, dev_doe, dev_ack, dev_ack_oe
  );
endinterface

// >>> logic/hbs_device.sv
/*
  Display controller end of the parallel host bus: strap capture, byte
  order, window decode into the display buffer and registers, and the
  active-high acknowledge handshake with display refresh arbitration.
  Assumes mclk is the host bus clock and straps are steady around reset.
*/
// Functional notes
// - Latch four straps and bus start at reset release.
// - Byte order strap high selects big endian.
// - Straps 111, bus start 0 give generic mode.
// - Acknowledge line is active high here.
// - Decode 128K window: buffer low, registers top.
// - Revision register readable repeatedly, no side effects.
// - Host chip select uses 16-bit port width.
// - Cycle ends on device acknowledge, not wait count.
// - Host asserts select half clock after address; the host here asserts it one full cycle after.
// - Host inhibits bursts; single beats only.
// - Host marks device region non-cacheable.
// - Hold host until data ready, refresh resolved.
// - Host drives byte strobes low per lane.
// - Host side runs from dedicated bus clock.
`timescale 1ns/1ps
module hbs_device (
  input wire logic mclk,
  input wire logic rst,
  hbs_if.device bus,
  input wire logic strap_bit_zero,
  input wire logic strap_bit_one,
  input wire logic strap_bit_two,
  input wire logic byte_order_strap,
  input wire logic bus_start_strap,
  input wire logic refresh_req,
  input wire logic [15:0] refresh_addr,
  output logic refresh_valid,
  output logic [15:0] refresh_data,
  output logic mode_ok,
  output logic big_endian
);
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ACCESS = 3'b001,
    DS_DATA = 3'b010,
    DS_HOLD = 3'b011
  } hbs_dev_state_e;

  typedef struct packed {
    logic latched;
    logic big_endian;
    logic mode_ok;
    hbs_dev_state_e state;
    logic [16:0] addr;
    logic is_write;
    logic [1:0] lanes;
    logic [15:0] wdata;
    logic [15:0] dout;
    logic doe;
    logic ack;
    logic ack_oe;
    logic ref_pend;
    logic refresh_valid;
    logic [15:0] refresh_data;
  } hbs_dev_s;

  hbs_dev_s cur;
  hbs_dev_s next_cur;
  logic [15:0] mem [0:hbs_pkg::BUF_WORDS-1];
  logic [15:0] mem_rdata;
  logic mem_en;
  logic mem_we;
  logic [15:0] mem_idx;
  logic [1:0] mem_be;
  logic [15:0] mem_wdata;
  logic strobe_any;
  logic [1:0] lanes_now;

  // Swaps byte lanes for big-endian hosts; memory keeps even byte low.
  function automatic logic [15:0] lane_swap(input logic swap, input logic [15:0] d);
    lane_swap = swap ? {d[7:0], d[15:8]} : d;
  endfunction

  // Strobes low select lanes: bit 0 is the low lane, bit 1 the high lane.
  assign lanes_now = bus.low_byte_write_strobe_n & bus.high_byte_write_strobe_n
    ? {~bus.high_byte_read_strobe_n, ~bus.low_byte_read_strobe_n}
    : {~bus.high_byte_write_strobe_n, ~bus.low_byte_write_strobe_n};
  assign strobe_any = |lanes_now;

  // Single memory port shared by host and refresh; refresh has priority.
  always_comb
  begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_idx = refresh_addr;
    mem_be = 2'b00;
    mem_wdata = lane_swap(cur.big_endian, cur.wdata);
    if (refresh_req)
    begin
      mem_en = 1'b1;
    end
    else if (cur.state == DS_ACCESS && cur.addr < hbs_pkg::BUF_END)
    begin
      mem_en = 1'b1;
      mem_we = cur.is_write;
      mem_idx = cur.addr[16:1];
      mem_be = cur.big_endian ? {cur.lanes[0], cur.lanes[1]} : cur.lanes;
    end
  end

  // Display buffer storage with byte lane writes.
  always_ff @(posedge mclk)
  begin
    if (mem_en && mem_idx < 16'(hbs_pkg::BUF_WORDS))
    begin
      if (mem_we && mem_be[0])
      begin
        mem[mem_idx][7:0] <= mem_wdata[7:0];
      end
      if (mem_we && mem_be[1])
      begin
        mem[mem_idx][15:8] <= mem_wdata[15:8];
      end
      mem_rdata <= mem[mem_idx];
    end
  end

  // Next-state logic for straps, bus handshake and refresh return.
  always_comb
  begin
    next_cur = cur;
    next_cur.ref_pend = refresh_req;
    next_cur.refresh_valid = cur.ref_pend;
    if (cur.ref_pend)
    begin
      next_cur.refresh_data = mem_rdata;
    end
    if (!cur.latched)
    begin
      next_cur.latched = 1'b1;
      next_cur.big_endian = byte_order_strap;
      next_cur.mode_ok = ({strap_bit_two, strap_bit_one, strap_bit_zero} == hbs_pkg::MODE_STRAPS)
        && (bus_start_strap == hbs_pkg::BUS_START_GENERIC);
    end
    // Acknowledge pin enable follows select one cycle late, and only in generic mode.
    next_cur.ack_oe = cur.mode_ok && !bus.cs_n;
    unique case (cur.state)
      DS_IDLE:
      begin
        next_cur.ack = 1'b0;
        next_cur.doe = 1'b0;
        if (cur.mode_ok && !bus.cs_n && strobe_any)
        begin
          next_cur.addr = bus.addr;
          next_cur.lanes = lanes_now;
          next_cur.is_write = ~(bus.low_byte_write_strobe_n & bus.high_byte_write_strobe_n);
          next_cur.wdata = bus.data_bus;
          next_cur.state = DS_ACCESS;
        end
      end
      DS_ACCESS:
      begin
        // Wait here while refresh holds the memory port.
        if (!refresh_req || cur.addr >= hbs_pkg::BUF_END)
        begin
          next_cur.state = DS_DATA;
        end
      end
      DS_DATA:
      begin
        if (cur.addr < hbs_pkg::BUF_END)
        begin
          next_cur.dout = lane_swap(cur.big_endian, mem_rdata);
        end
        else if (cur.addr >= hbs_pkg::REG_BASE && cur.addr[4:1] == hbs_pkg::REV_REG_OFS[4:1])
        begin
          next_cur.dout = lane_swap(cur.big_endian, {8'h00, hbs_pkg::REV_CODE});
        end
        else
        begin
          next_cur.dout = 16'h0000;
        end
        next_cur.doe = !cur.is_write;
        next_cur.ack = 1'b1;
        next_cur.state = DS_HOLD;
      end
      DS_HOLD:
      begin
        // Keep the acknowledge up until the host drops select.
        if (bus.cs_n)
        begin
          next_cur.ack = 1'b0;
          next_cur.doe = 1'b0;
          next_cur.state = DS_IDLE;
        end
      end
      default:
      begin
        next_cur.state = DS_IDLE;
      end
    endcase
  end

  // State register, clocked by the host bus clock only.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Pins and status straight from the state register.
  assign bus.dev_dout = cur.dout;
  assign bus.dev_doe = cur.doe;
  assign bus.dev_ack = cur.ack;
  assign bus.dev_ack_oe = cur.ack_oe;
  assign refresh_valid = cur.refresh_valid;
  assign refresh_data = cur.refresh_data;
  assign mode_ok = cur.mode_ok;
  assign big_endian = cur.big_endian;
endmodule

// >>> logic/hbs_host.sv
/*
  Host bus controller end: an AXI4-Lite register slave takes one bus
  command at a time and runs a single-beat 16-bit cycle on the pins,
  ending it on the device acknowledge.
  Assumes the device end shares mclk and the pull-down on acknowledge.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hbs_host (
  input wire logic mclk,
  input wire logic rst,
  hbs_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_WAIT = 2'b10
  } hbs_host_state_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cmd;
    logic [16:0] taddr;
    logic [15:0] twdata;
    logic [15:0] trdata;
    logic busy;
    logic done;
    hbs_host_state_e state;
    logic [16:0] addr;
    logic cs_n;
    logic [1:0] we_n;
    logic [1:0] rd_n;
    logic [15:0] dout;
    logic doe;
  } hbs_host_s;

  hbs_host_s cur;
  hbs_host_s next_cur;

  // Merges the enabled byte lanes of a write into a register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Register slave, command launch and pin sequencer.
  always_comb
  begin
    next_cur = cur;
    next_cur.awready = !cur.aw_got && !cur.bvalid;
    next_cur.wready = !cur.w_got && !cur.bvalid;
    if (s_axi_awvalid && cur.awready)
    begin
      next_cur.aw_got = 1'b1;
      next_cur.awaddr = s_axi_awaddr;
      next_cur.awready = 1'b0;
    end
    if (s_axi_wvalid && cur.wready)
    begin
      next_cur.w_got = 1'b1;
      next_cur.wdata = s_axi_wdata;
      next_cur.wstrb = s_axi_wstrb;
      next_cur.wready = 1'b0;
    end
    if (cur.bvalid && s_axi_bready)
    begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.aw_got && cur.w_got && !cur.bvalid)
    begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = hbs_pkg::RESP_OKAY;
      unique case (cur.awaddr)
        hbs_pkg::CMD_OFS:
        begin
          next_cur.cmd = merge(cur.cmd, cur.wdata, cur.wstrb);
          if (!cur.busy && cur.wstrb[0] && cur.wdata[hbs_pkg::CMD_GO_BIT])
          begin
            next_cur.busy = 1'b1;
            next_cur.done = 1'b0;
          end
        end
        hbs_pkg::ADDR_OFS:
        begin
          next_cur.taddr = 17'(merge({15'h0000, cur.taddr}, cur.wdata, cur.wstrb));
        end
        hbs_pkg::WDATA_OFS:
        begin
          next_cur.twdata = 16'(merge({16'h0000, cur.twdata}, cur.wdata, cur.wstrb));
        end
        default:
        begin
          next_cur.bresp = hbs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Reads answer one cycle after the address is taken.
    next_cur.arready = !cur.rvalid && !cur.arready;
    if (cur.rvalid && s_axi_rready)
    begin
      next_cur.rvalid = 1'b0;
    end
    if (s_axi_arvalid && cur.arready)
    begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = hbs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        hbs_pkg::CMD_OFS: next_cur.rdata = cur.cmd;
        hbs_pkg::ADDR_OFS: next_cur.rdata = {15'h0000, cur.taddr};
        hbs_pkg::WDATA_OFS: next_cur.rdata = {16'h0000, cur.twdata};
        hbs_pkg::STATUS_OFS: next_cur.rdata = {30'h00000000, cur.done, cur.busy};
        hbs_pkg::RDATA_OFS: next_cur.rdata = {16'h0000, cur.trdata};
        default:
        begin
          next_cur.rdata = 32'h00000000;
          next_cur.rresp = hbs_pkg::RESP_SLVERR;
        end
      endcase
    end
    unique case (cur.state)
      HS_IDLE:
      begin
        if (cur.busy)
        begin
          // Address and write data go out one cycle before select.
          next_cur.addr = cur.taddr;
          next_cur.dout = cur.twdata;
          next_cur.doe = cur.cmd[hbs_pkg::CMD_WRITE_BIT];
          next_cur.state = HS_SETUP;
        end
      end
      HS_SETUP:
      begin
        next_cur.cs_n = 1'b0;
        if (cur.cmd[hbs_pkg::CMD_WRITE_BIT])
        begin
          next_cur.we_n = ~cur.cmd[hbs_pkg::CMD_LANE_LSB +: 2];
        end
        else
        begin
          next_cur.rd_n = ~cur.cmd[hbs_pkg::CMD_LANE_LSB +: 2];
        end
        next_cur.state = HS_WAIT;
      end
      HS_WAIT:
      begin
        // One 16-bit beat ends only on the active-high acknowledge.
        if (bus.ack_line)
        begin
          next_cur.trdata = bus.data_bus;
          next_cur.cs_n = 1'b1;
          next_cur.we_n = 2'b11;
          next_cur.rd_n = 2'b11;
          next_cur.doe = 1'b0;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
          next_cur.state = HS_IDLE;
        end
      end
      default:
      begin
        next_cur.state = HS_IDLE;
      end
    endcase
  end

  // State register; pin strobes idle high.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.cs_n <= 1'b1;
      cur.we_n <= 2'b11;
      cur.rd_n <= 2'b11;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register.
  assign bus.addr = cur.addr;
  assign bus.cs_n = cur.cs_n;
  assign bus.low_byte_write_strobe_n = cur.we_n[0];
  assign bus.high_byte_write_strobe_n = cur.we_n[1];
  assign bus.low_byte_read_strobe_n = cur.rd_n[0];
  assign bus.high_byte_read_strobe_n = cur.rd_n[1];
  assign bus.host_dout = cur.dout;
  assign bus.host_doe = cur.doe;
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
endmodule

// >>> dv/hbs_checker.sv
/*
  Concurrent checks on the pin bus that joins the host end and the device end.
  Assumes one clock, rst asynchronous active high, and generic mode while cycles run.
*/
`timescale 1ns/1ps
module hbs_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [16:0] addr,
  input wire logic cs_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic high_byte_write_strobe_n,
  input wire logic low_byte_read_strobe_n,
  input wire logic high_byte_read_strobe_n,
  input wire logic [15:0] host_dout,
  input wire logic host_doe,
  input wire logic dev_doe,
  input wire logic dev_ack,
  input wire logic dev_ack_oe,
  input wire logic ack_line
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // The acknowledge is enabled early and rises only inside a selected cycle.
  a_ack_in_cycle: assert property ($rose(dev_ack) |-> !cs_n && dev_ack_oe)
    else $error("ack raised outside a selected cycle");
  a_ack_oe_early: assert property ($fell(cs_n) |=> dev_ack_oe)
    else $error("ack enable late after select");
  a_ack_bounded: assert property ($fell(cs_n) |-> ##[1:40] ack_line)
    else $error("cycle never acknowledged");

  // The host ends each cycle on the acknowledge and nothing else.
  a_hold_till_ack: assert property (!cs_n && !ack_line |=> !cs_n)
    else $error("select released before ack");
  a_release_on_ack: assert property (!cs_n && ack_line |=> cs_n)
    else $error("select held after ack");
  a_ack_withdrawn: assert property (cs_n && dev_ack |=> !dev_ack && !dev_doe)
    else $error("device kept ack or data after deselect");

  // Single beats with an idle gap, address settled before select.
  a_idle_gap: assert property ($rose(cs_n) |=> cs_n)
    else $error("back to back select without idle");
  a_addr_steady: assert property (!cs_n |-> $stable(addr))
    else $error("address moved during select");

  // Byte strobes and data lanes are used without a fight.
  a_strobe_used: assert property (!cs_n |-> !(low_byte_write_strobe_n && high_byte_write_strobe_n
    && low_byte_read_strobe_n && high_byte_read_strobe_n))
    else $error("select without any strobe");
  a_no_contention: assert property (!(dev_doe && host_doe))
    else $error("both ends drive data");
  a_wdata_steady: assert property (!cs_n && host_doe |-> $stable(host_dout))
    else $error("write data moved during select");
endmodule

// >>> dv/testbench.sv
/*
  Self-checking bench: host and device ends joined by hbs_if, software side over AXI4-Lite.
  Assumes hbs_pkg, hbs_if and both design ends are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk, rst, refresh_req, refresh_valid, mode_ok, big_endian;
  logic [4:0] strap; // Byte order, two, one, zero, bus start.
  logic [15:0] refresh_addr, refresh_data, q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, s;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail, num_checks, cnt;

  hbs_if ifc();
  hbs_device hbs_device_i (.mclk, .rst, .bus(ifc.device), .strap_bit_zero(strap[1]), .strap_bit_one(strap[2]),
    .strap_bit_two(strap[3]), .byte_order_strap(strap[4]), .bus_start_strap(strap[0]), .refresh_req,
    .refresh_addr, .refresh_valid, .refresh_data, .mode_ok, .big_endian);
  hbs_host hbs_host_i (.mclk, .rst, .bus(ifc.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  hbs_checker chk_i (.mclk, .rst, .addr(ifc.addr), .cs_n(ifc.cs_n),
    .low_byte_write_strobe_n(ifc.low_byte_write_strobe_n), .high_byte_write_strobe_n(ifc.high_byte_write_strobe_n),
    .low_byte_read_strobe_n(ifc.low_byte_read_strobe_n), .high_byte_read_strobe_n(ifc.high_byte_read_strobe_n),
    .host_dout(ifc.host_dout), .host_doe(ifc.host_doe), .dev_doe(ifc.dev_doe), .dev_ack(ifc.dev_ack),
    .dev_ack_oe(ifc.dev_ack_oe), .ack_line(ifc.ack_line));

  // Free-running 200 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // A bounded wait ran out.
  task automatic hang();
    n_fail++;
    $display("ERROR t=%0t wait ran out", $time);
    tally_and_finish();
  endtask

  // One AXI4-Lite write; address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; (aw || w) && n < 100; n++)
    begin
      @(posedge mclk);
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (aw || w)
      hang();
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1)
      hang();
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // One AXI4-Lite read, holding rready until the answer is sampled.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (s_axi_arready !== 1'b1 && n < 100);
    if (s_axi_arready !== 1'b1)
      hang();
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1)
      hang();
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One pin bus cycle run through the controller's registers.
  task automatic pin(input logic [16:0] a, input logic wr, input logic [1:0] ln, input logic [15:0] d,
    output logic [15:0] rd);
    logic [31:0] st;
    logic [1:0] rr;
    int n;
    axi_wr(hbs_pkg::ADDR_OFS, {15'h0000, a}, hbs_pkg::RESP_OKAY);
    axi_wr(hbs_pkg::WDATA_OFS, {16'h0000, d}, hbs_pkg::RESP_OKAY);
    axi_wr(hbs_pkg::CMD_OFS, {28'h0000000, ln, wr, 1'b1}, hbs_pkg::RESP_OKAY);
    st = '0;
    for (n = 0; st[hbs_pkg::STAT_DONE_BIT] !== 1'b1 && n < 100; n++)
      axi_rd(hbs_pkg::STATUS_OFS, st, rr);
    if (st[hbs_pkg::STAT_DONE_BIT] !== 1'b1)
      hang();
    axi_rd(hbs_pkg::RDATA_OFS, st, rr);
    rd = st[15:0];
  endtask

  // Holds reset three cycles with the given straps, then waits two cycles with reset released.
  task automatic do_reset(input logic [4:0] sv);
    rst <= 1'b1;
    strap <= sv;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // Refresh wins the memory four cycles in mid-access; counts the answers.
  task automatic refresh_burst();
    int n;
    for (n = 0; ifc.cs_n !== 1'b0 && n < 200; n++)
      @(posedge mclk);
    if (ifc.cs_n !== 1'b0)
      hang();
    refresh_req <= 1'b1;
    cnt = 0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge mclk);
      if (n == 3)
        refresh_req <= 1'b0;
      if (refresh_valid === 1'b1)
      begin
        cnt++;
        chk({16'h0, refresh_data}, 32'h0000cd12);
      end
    end
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    strap = 5'b11110;
    refresh_req = 1'b0;
    refresh_addr = 16'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    n_fail = 0;
    num_checks = 0;
    do_reset(5'b11110);
    chk({31'h0, mode_ok}, 32'h1);
    chk({31'h0, big_endian}, 32'h1);
    strap <= 5'b00001;
    repeat (2) @(posedge mclk);
    chk({31'h0, mode_ok}, 32'h1);
    chk({31'h0, big_endian}, 32'h1);
    strap <= 5'b11110;
    for (int i = 0; i < 2; i++)
    begin
      pin(hbs_pkg::REG_BASE, 1'b0, 2'b11, 16'h0000, q);
      chk({24'h0, q[15:8]}, {24'h0, hbs_pkg::REV_CODE});
    end
    pin(hbs_pkg::REG_BASE, 1'b1, 2'b11, 16'hffff, q);
    pin(hbs_pkg::REG_BASE, 1'b0, 2'b11, 16'h0000, q);
    chk({24'h0, q[15:8]}, {24'h0, hbs_pkg::REV_CODE});
    pin(hbs_pkg::BUF_END - 17'h2, 1'b1, 2'b11, 16'hbeef, q);
    pin(hbs_pkg::BUF_END - 17'h2, 1'b0, 2'b11, 16'h0000, q);
    chk({16'h0, q}, 32'h0000beef);
    pin(17'h00000, 1'b1, 2'b11, 16'h1234, q);
    pin(17'h00000, 1'b1, 2'b01, 16'h00cd, q);
    pin(hbs_pkg::BUF_END, 1'b1, 2'b11, 16'h5555, q);
    pin(hbs_pkg::BUF_END, 1'b0, 2'b11, 16'h0000, q);
    chk({16'h0, q}, 32'h00000000);
    fork
      pin(17'h00000, 1'b0, 2'b11, 16'h0000, q);
      refresh_burst();
    join
    chk({16'h0, q}, 32'h000012cd);
    chk(cnt, 32'h4);
    axi_wr(8'h20, 32'h0, hbs_pkg::RESP_SLVERR);
    axi_rd(8'h20, s, r);
    chk({s[31:2], r}, {30'h0, hbs_pkg::RESP_SLVERR});
    do_reset(5'b01110);
    chk({31'h0, big_endian}, 32'h0);
    pin(hbs_pkg::REG_BASE, 1'b0, 2'b11, 16'h0000, q);
    chk({24'h0, q[7:0]}, {24'h0, hbs_pkg::REV_CODE});
    do_reset(5'b11100);
    chk({31'h0, mode_ok}, 32'h0);
    do_reset(5'b11111);
    chk({31'h0, mode_ok}, 32'h0);
    tally_and_finish();
  end
endmodule
